// ===== src/ccrb_bank.sv
// Top of the codec control register bank: serial-word access, storage and control outputs.
// Behaviour
// - Word bits 12..8 address the register, bits 7..0 carry its data.
// - Word bit 13 low writes, high reads.
// - Register 0 is no-op; 1 to 4 are controls; bits 15,14 zero.
// - Control 1 bit 7 gives one software reset, then clears itself.
// - Control 1 bit 6 powers down analog section and filters.
// - Control 1 bit 5 routes auxiliary pair to the ADC, else main.
// - Control 1 bit 4 routes auxiliary pair to monitor, else main.
// - Control 1 bits 3,2 set monitor gain: -18, -8, 0 dB, mute.
// - Control 1 bit 1 enables digital loopback.
// - Control 1 bit 0 selects 16-bit DAC mode with pin requests.
// - All four control registers reset to zero.
// - Control 2 bit 5 reads back the decimator overflow condition.
// - Control 2 bit 3 enables analog loopback.
// - Control 2 bit 2 low enables delayed frame sync, high disables.
// - Control 3 bits 5..0 count bit clocks to delayed frame sync, min 18.
// - Control 3 bits 7,6 hold the number of slave devices.
// - Control 4 bits 3,2 set input gain: mute, 12, 6, 0 dB.
// - Control 4 bits 1,0 set output gain: mute, -12, -6, 0 dB.
// - Control 4 bits 6..4 give divisor N, zero meaning eight.
`timescale 1ns/1ns
`include "ccrb_defs.svh"
module ccrb_bank
(
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic WORD_VALID_I,
    input wire logic [15:0] WORD_I,
    input wire logic FIR_OVERFLOW_I,
    output logic [15:0] READ_WORD_O,
    output logic READ_VALID_O,
    output logic SOFT_RESET_O,
    output logic POWER_DOWN_O,
    output logic ADC_AUX_SEL_O,
    output logic MON_AUX_SEL_O,
    output logic [1:0] MON_GAIN_O,
    output logic DIG_LOOPBACK_O,
    output logic DAC16_MODE_O,
    output logic FLAG_O,
    output logic PHONE_MODE_O,
    output logic ADC16_MODE_O,
    output logic ANA_LOOPBACK_O,
    output logic DELAYED_FRAME_SYNC_EN_O,
    output logic [5:0] FRAME_DELAY_O,
    output logic FRAME_DELAY_BELOW_MIN_O,
    output logic [1:0] SLAVE_COUNT_O,
    output logic SLOTS_ACTIVE_O,
    output logic PLL_BYPASS_O,
    output logic [3:0] RATE_DIVISOR_O,
    output logic [1:0] IN_GAIN_O,
    output logic [1:0] OUT_GAIN_O
);
    ccrb_pkg::ccrb_cmd_s cmd;
    ccrb_pkg::ccrb_ctrl_s ctrl;
    ccrb_pkg::ccrb_state_e state_q;
    ccrb_pkg::ccrb_state_e state_d;
    logic [7:0] regs_q [1:4];
    logic [7:0] regs_d [1:4];
    logic ovf_q;
    logic slots_q;
    logic [7:0] rd_byte;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] n);
        hit = (a == n);
    endfunction : hit

    ccrb_decode u_decode
    (
        .word_valid_i(WORD_VALID_I),
        .word_i(WORD_I),
        .cmd_o(cmd)
    );

    // Register writes; no-op and unmapped numbers fall through untouched.
    genvar gi;
    generate
        for (gi = 1; gi <= 4; gi++)
        begin : g_reg
            assign regs_d[gi] = (cmd.wr && hit(cmd.addr, 5'(gi))) ? cmd.data : regs_q[gi];
            if (gi == 1)
            begin : g_c1
                // The reset bit is held for two cycles, the capture and the clear cycle, then dropped by hardware.
                // A host write in the clear cycle wins, so no setting is ever lost.
                always_ff @(posedge REF_CLK_I or negedge NRST_I)
                begin
                    if (!NRST_I)
                        regs_q[gi] <= `CCRB_RESET_VAL;
                    else if (state_q == ccrb_pkg::ST_RESET && !(cmd.wr && hit(cmd.addr, `CCRB_REG_CTRL1)))
                        regs_q[gi] <= regs_q[gi] & ~(8'h01 << `CCRB_C1_SWRESET);
                    else
                        regs_q[gi] <= regs_d[gi];
                end
            end
            else
            begin : g_cn
                always_ff @(posedge REF_CLK_I or negedge NRST_I)
                begin
                    if (!NRST_I)
                        regs_q[gi] <= `CCRB_RESET_VAL;
                    else
                        regs_q[gi] <= regs_d[gi];
                end
            end
        end
    endgenerate

    // The clear state lasts one cycle; a reset bit written during it keeps the bit set and stretches the pulse by two clocks.
    assign state_d = (state_q == ccrb_pkg::ST_RESET) ? ccrb_pkg::ST_IDLE :
                     (regs_q[1][`CCRB_C1_SWRESET] ? ccrb_pkg::ST_RESET : ccrb_pkg::ST_IDLE);

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            state_q <= ccrb_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    ccrb_fields u_fields
    (
        .c1_i(regs_q[1]),
        .c2_i(regs_q[2]),
        .c3_i(regs_q[3]),
        .c4_i(regs_q[4]),
        .ctrl_o(ctrl)
    );

    // The overflow bit is a live status, not a register bit, so reads see the input through one flop.
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            ovf_q <= 1'b0;
        else
            ovf_q <= FIR_OVERFLOW_I;
    end

    wire [7:0] c2_read = {regs_q[2][7:6], ovf_q, regs_q[2][4:0]};
    assign rd_byte = hit(cmd.addr, `CCRB_REG_CTRL1) ? regs_q[1] :
                     hit(cmd.addr, `CCRB_REG_CTRL2) ? c2_read :
                     hit(cmd.addr, `CCRB_REG_CTRL3) ? regs_q[3] :
                     hit(cmd.addr, `CCRB_REG_CTRL4) ? regs_q[4] : 8'h00;

    // Time slots stay off until register 3 has been written after reset.
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            slots_q <= 1'b0;
        else if (cmd.wr && hit(cmd.addr, `CCRB_REG_CTRL3))
            slots_q <= 1'b1;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            READ_VALID_O <= 1'b0;
        else
            READ_VALID_O <= cmd.rd;
    end

    // The read word holds between reads, so a slow host can still pick it up.
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            READ_WORD_O <= 16'h0000;
        else if (cmd.rd)
            READ_WORD_O <= {8'h00, rd_byte};
    end

    // Every control pin has a flop of its own, so no pin ever shows a decode glitch.
    // The pulse spans the capture cycle and the clear cycle, two clocks in all.
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            SOFT_RESET_O <= 1'b0;
        else
            SOFT_RESET_O <= ctrl.soft_reset;
    end

    // Power down is only a level to the analog side; the bank keeps running so the host can undo it.
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            POWER_DOWN_O <= 1'b0;
        else
            POWER_DOWN_O <= ctrl.power_down;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            ADC_AUX_SEL_O <= 1'b0;
        else
            ADC_AUX_SEL_O <= ctrl.adc_aux;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            MON_AUX_SEL_O <= 1'b0;
        else
            MON_AUX_SEL_O <= ctrl.mon_aux;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            MON_GAIN_O <= 2'h0;
        else
            MON_GAIN_O <= ctrl.mon_gain;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            DIG_LOOPBACK_O <= 1'b0;
        else
            DIG_LOOPBACK_O <= ctrl.dig_loop;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            DAC16_MODE_O <= 1'b0;
        else
            DAC16_MODE_O <= ctrl.dac16;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            FLAG_O <= 1'b0;
        else
            FLAG_O <= ctrl.flag;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            PHONE_MODE_O <= 1'b0;
        else
            PHONE_MODE_O <= ctrl.phone;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            ADC16_MODE_O <= 1'b0;
        else
            ADC16_MODE_O <= ctrl.adc16;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            ANA_LOOPBACK_O <= 1'b0;
        else
            ANA_LOOPBACK_O <= ctrl.ana_loop;
    end

    // The enable is the inverse of the stored bit, so it comes up high one edge after reset.
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            DELAYED_FRAME_SYNC_EN_O <= 1'b0;
        else
            DELAYED_FRAME_SYNC_EN_O <= ~ctrl.dfs_off;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            FRAME_DELAY_O <= 6'h00;
        else
            FRAME_DELAY_O <= ctrl.fs_delay;
    end

    // Below-minimum delays are flagged, not clamped, so the host sees its own value.
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            FRAME_DELAY_BELOW_MIN_O <= 1'b0;
        else
            FRAME_DELAY_BELOW_MIN_O <= (ctrl.fs_delay < `CCRB_C3_DLY_MIN);
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            SLAVE_COUNT_O <= 2'h0;
        else
            SLAVE_COUNT_O <= ctrl.slaves;
    end

    // Slots open only after register 3, so the global setup reaches every device first.
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            SLOTS_ACTIVE_O <= 1'b0;
        else
            SLOTS_ACTIVE_O <= slots_q;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            PLL_BYPASS_O <= 1'b0;
        else
            PLL_BYPASS_O <= ctrl.pll_bypass;
    end

    // During reset the divisor reads zero; the decoded eight appears one edge later.
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            RATE_DIVISOR_O <= 4'h0;
        else
            RATE_DIVISOR_O <= ctrl.rate_n;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            IN_GAIN_O <= 2'h0;
        else
            IN_GAIN_O <= ctrl.in_gain;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            OUT_GAIN_O <= 2'h0;
        else
            OUT_GAIN_O <= ctrl.out_gain;
    end
endmodule : ccrb_bank

// ===== src/ccrb_decode.sv
// Decoder that splits a secondary serial word into a register command.
`timescale 1ns/1ns
`include "ccrb_defs.svh"
module ccrb_decode
(
    input wire logic word_valid_i,
    input wire logic [15:0] word_i,
    output ccrb_pkg::ccrb_cmd_s cmd_o
);
    wire top_zero = (word_i[`CCRB_TOP_HI:`CCRB_TOP_LO] == 2'h0);
    wire [4:0] addr = word_i[`CCRB_ADDR_HI:`CCRB_ADDR_LO];
    wire is_read = word_i[`CCRB_RW_BIT];
    // Words with either top bit set are not register accesses and are dropped.
    assign cmd_o.wr = word_valid_i & top_zero & ~is_read;
    assign cmd_o.rd = word_valid_i & top_zero & is_read;
    assign cmd_o.addr = addr;
    assign cmd_o.data = word_i[7:0];
endmodule : ccrb_decode

// ===== src/ccrb_defs.svh
// Constants for the codec control register bank: word fields, offsets, bit positions and reset values.
`ifndef CCRB_DEFS_SVH
`define CCRB_DEFS_SVH
`define CCRB_ADDR_HI 12
`define CCRB_ADDR_LO 8
`define CCRB_RW_BIT 13
`define CCRB_TOP_HI 15
`define CCRB_TOP_LO 14
`define CCRB_REG_NOP 5'h00
`define CCRB_REG_CTRL1 5'h01
`define CCRB_REG_CTRL2 5'h02
`define CCRB_REG_CTRL3 5'h03
`define CCRB_REG_CTRL4 5'h04
`define CCRB_RESET_VAL 8'h00
`define CCRB_C1_SWRESET 7
`define CCRB_C1_PWRDN 6
`define CCRB_C1_ADC_AUX 5
`define CCRB_C1_MON_AUX 4
`define CCRB_C1_MON_HI 3
`define CCRB_C1_MON_LO 2
`define CCRB_C1_DLOOP 1
`define CCRB_C1_DAC16 0
`define CCRB_C2_FLAG 7
`define CCRB_C2_PHONE 6
`define CCRB_C2_OVF 5
`define CCRB_C2_ADC16 4
`define CCRB_C2_ALOOP 3
`define CCRB_C2_DFS_OFF 2
`define CCRB_C3_DLY_HI 5
`define CCRB_C3_DLY_LO 0
`define CCRB_C3_SLV_HI 7
`define CCRB_C3_SLV_LO 6
`define CCRB_C3_DLY_MIN 6'h12
`define CCRB_C4_PLL_BYP 7
`define CCRB_C4_N_HI 6
`define CCRB_C4_N_LO 4
`define CCRB_C4_IN_HI 3
`define CCRB_C4_IN_LO 2
`define CCRB_C4_OUT_HI 1
`define CCRB_C4_OUT_LO 0
`define CCRB_N_ZERO 3'h0
`define CCRB_N_EIGHT 4'h8
`endif

// ===== src/ccrb_fields.sv
// Field unpacking of the four control registers into named controls.
`timescale 1ns/1ns
`include "ccrb_defs.svh"
module ccrb_fields
(
    input wire logic [7:0] c1_i,
    input wire logic [7:0] c2_i,
    input wire logic [7:0] c3_i,
    input wire logic [7:0] c4_i,
    output ccrb_pkg::ccrb_ctrl_s ctrl_o
);
    wire [2:0] n_raw = c4_i[`CCRB_C4_N_HI:`CCRB_C4_N_LO];
    assign ctrl_o.soft_reset = c1_i[`CCRB_C1_SWRESET];
    assign ctrl_o.power_down = c1_i[`CCRB_C1_PWRDN];
    assign ctrl_o.adc_aux = c1_i[`CCRB_C1_ADC_AUX];
    assign ctrl_o.mon_aux = c1_i[`CCRB_C1_MON_AUX];
    assign ctrl_o.mon_gain = ccrb_pkg::ccrb_mon_gain_e'(c1_i[`CCRB_C1_MON_HI:`CCRB_C1_MON_LO]);
    assign ctrl_o.dig_loop = c1_i[`CCRB_C1_DLOOP];
    assign ctrl_o.dac16 = c1_i[`CCRB_C1_DAC16];
    assign ctrl_o.flag = c2_i[`CCRB_C2_FLAG];
    assign ctrl_o.phone = c2_i[`CCRB_C2_PHONE];
    assign ctrl_o.adc16 = c2_i[`CCRB_C2_ADC16];
    assign ctrl_o.ana_loop = c2_i[`CCRB_C2_ALOOP];
    assign ctrl_o.dfs_off = c2_i[`CCRB_C2_DFS_OFF];
    assign ctrl_o.fs_delay = c3_i[`CCRB_C3_DLY_HI:`CCRB_C3_DLY_LO];
    assign ctrl_o.slaves = c3_i[`CCRB_C3_SLV_HI:`CCRB_C3_SLV_LO];
    assign ctrl_o.pll_bypass = c4_i[`CCRB_C4_PLL_BYP];
    // Zero in the divisor field stands for eight, so the decoded value needs four bits.
    assign ctrl_o.rate_n = (n_raw == `CCRB_N_ZERO) ? `CCRB_N_EIGHT : {1'b0, n_raw};
    assign ctrl_o.in_gain = ccrb_pkg::ccrb_in_gain_e'(c4_i[`CCRB_C4_IN_HI:`CCRB_C4_IN_LO]);
    assign ctrl_o.out_gain = ccrb_pkg::ccrb_out_gain_e'(c4_i[`CCRB_C4_OUT_HI:`CCRB_C4_OUT_LO]);
endmodule : ccrb_fields

// ===== src/ccrb_pkg.sv
// Types for the codec control register bank.
package ccrb_pkg;
    typedef enum logic [1:0]
    {
        MON_MUTE = 2'h0,
        MON_0DB = 2'h1,
        MON_M8DB = 2'h2,
        MON_M18DB = 2'h3
    } ccrb_mon_gain_e;
    typedef enum logic [1:0]
    {
        IN_0DB = 2'h0,
        IN_6DB = 2'h1,
        IN_12DB = 2'h2,
        IN_MUTE = 2'h3
    } ccrb_in_gain_e;
    typedef enum logic [1:0]
    {
        OUT_0DB = 2'h0,
        OUT_M6DB = 2'h1,
        OUT_M12DB = 2'h2,
        OUT_MUTE = 2'h3
    } ccrb_out_gain_e;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_RESET = 2'h1
    } ccrb_state_e;
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] data;
    } ccrb_cmd_s;
    typedef struct packed
    {
        logic soft_reset;
        logic power_down;
        logic adc_aux;
        logic mon_aux;
        ccrb_mon_gain_e mon_gain;
        logic dig_loop;
        logic dac16;
        logic flag;
        logic phone;
        logic adc16;
        logic ana_loop;
        logic dfs_off;
        logic [5:0] fs_delay;
        logic [1:0] slaves;
        logic pll_bypass;
        logic [3:0] rate_n;
        ccrb_in_gain_e in_gain;
        ccrb_out_gain_e out_gain;
    } ccrb_ctrl_s;
endpackage : ccrb_pkg

// ===== tb/ccrb_host.sv
// Host serial port model that hands secondary words to the bank.
`timescale 1ns/1ns
module ccrb_host
(
    input wire logic clk_i,
    output logic valid_o,
    output logic [15:0] word_o
);
    initial
    begin
        valid_o = 1'b0;
        word_o = 16'hA5C3;
    end
    // The word is held until the next call, so calls in a row give back-to-back words.
    task automatic send(input logic rd, input logic [4:0] ad, input logic [7:0] d, input logic [1:0] top);
        @(negedge clk_i);
        valid_o = 1'b1;
        word_o = {top, rd, ad, d};
    endtask : send
    // Idle lines show the inverse of the last word so stale data never looks valid.
    task automatic idle();
        @(negedge clk_i);
        valid_o = 1'b0;
        word_o = ~word_o;
    endtask : idle
endmodule : ccrb_host

// ===== tb/ccrb_props.sv
// Port checker of the control register bank.
`timescale 1ns/1ns
module ccrb_props
(
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic WORD_VALID_I,
    input wire logic [15:0] WORD_I,
    input wire logic [15:0] READ_WORD_O,
    input wire logic READ_VALID_O,
    input wire logic SOFT_RESET_O,
    input wire logic POWER_DOWN_O,
    input wire logic [1:0] MON_GAIN_O,
    input wire logic FLAG_O,
    input wire logic DELAYED_FRAME_SYNC_EN_O,
    input wire logic [5:0] FRAME_DELAY_O,
    input wire logic FRAME_DELAY_BELOW_MIN_O,
    input wire logic [1:0] SLAVE_COUNT_O,
    input wire logic SLOTS_ACTIVE_O,
    input wire logic PLL_BYPASS_O,
    input wire logic [3:0] RATE_DIVISOR_O,
    input wire logic [1:0] IN_GAIN_O,
    input wire logic [1:0] OUT_GAIN_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!NRST_I);
    wire logic wr_ok = WORD_VALID_I && WORD_I[15:13] == 3'h0;
    wire logic [4:0] ad = WORD_I[12:8];
    a_ctrl1_fields: assert property (wr_ok && ad == 5'h01 && !WORD_I[7] |-> ##2
        {POWER_DOWN_O, MON_GAIN_O} == {$past(WORD_I[6], 2), $past(WORD_I[3:2], 2)})
        else $error("control 1 outputs wrong");
    a_soft_pulse: assert property (wr_ok && ad == 5'h01 && WORD_I[7] |-> ##2 SOFT_RESET_O [*2] ##1 !SOFT_RESET_O)
        else $error("soft reset pulse wrong");
    a_ctrl2_fields: assert property (wr_ok && ad == 5'h02 |-> ##2
        {FLAG_O, DELAYED_FRAME_SYNC_EN_O} == {$past(WORD_I[7], 2), !$past(WORD_I[2], 2)})
        else $error("control 2 outputs wrong");
    a_ctrl3_fields: assert property (wr_ok && ad == 5'h03 |-> ##2 SLOTS_ACTIVE_O &&
        {SLAVE_COUNT_O, FRAME_DELAY_O} == $past(WORD_I[7:0], 2) &&
        FRAME_DELAY_BELOW_MIN_O == ($past(WORD_I[5:0], 2) < 6'h12))
        else $error("control 3 outputs wrong");
    a_ctrl4_fields: assert property (wr_ok && ad == 5'h04 |-> ##2
        {PLL_BYPASS_O, IN_GAIN_O, OUT_GAIN_O} == {$past(WORD_I[7], 2), $past(WORD_I[3:0], 2)})
        else $error("control 4 outputs wrong");
    a_rate_decode: assert property (wr_ok && ad == 5'h04 |-> ##2 RATE_DIVISOR_O ==
        ($past(WORD_I[6:4], 2) == 3'h0 ? 4'h8 : {1'b0, $past(WORD_I[6:4], 2)}))
        else $error("rate divisor wrong");
    a_read_answer: assert property (WORD_VALID_I && WORD_I[15:13] == 3'h1 |-> ##[1:2] READ_VALID_O)
        else $error("read not answered");
    a_read_high: assert property (READ_VALID_O |-> READ_WORD_O[15:8] == 8'h00)
        else $error("read word high byte not zero");
    a_top_ignored: assert property (WORD_VALID_I && WORD_I[15:14] != 2'h0 && !SOFT_RESET_O |-> ##2
        $stable({PLL_BYPASS_O, IN_GAIN_O, OUT_GAIN_O, FLAG_O, FRAME_DELAY_O}))
        else $error("word with top bits set was taken");
endmodule : ccrb_props
bind ccrb_bank ccrb_props u_props (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .WORD_VALID_I(WORD_VALID_I),
    .WORD_I(WORD_I), .READ_WORD_O(READ_WORD_O), .READ_VALID_O(READ_VALID_O), .SOFT_RESET_O(SOFT_RESET_O),
    .POWER_DOWN_O(POWER_DOWN_O), .MON_GAIN_O(MON_GAIN_O), .FLAG_O(FLAG_O), .FRAME_DELAY_O(FRAME_DELAY_O),
    .DELAYED_FRAME_SYNC_EN_O(DELAYED_FRAME_SYNC_EN_O), .FRAME_DELAY_BELOW_MIN_O(FRAME_DELAY_BELOW_MIN_O),
    .SLAVE_COUNT_O(SLAVE_COUNT_O), .SLOTS_ACTIVE_O(SLOTS_ACTIVE_O), .PLL_BYPASS_O(PLL_BYPASS_O),
    .RATE_DIVISOR_O(RATE_DIVISOR_O), .IN_GAIN_O(IN_GAIN_O), .OUT_GAIN_O(OUT_GAIN_O));

// ===== tb/testbench.sv
// Self-checking bench of the control register bank.
`timescale 1ns/1ns
module testbench;
    logic clk, nrst, fir, valid, rvalid, sreset, pdn, adc_aux, mon_aux, dloop, dac16;
    logic flag, phone, adc16, aloop, dfs_en, below, slots, byp;
    logic [15:0] word, rword;
    logic [1:0] mon_g, slv, in_g, out_g;
    logic [5:0] dly;
    logic [3:0] rate;
    logic [7:0] r [5];
    int errors = 0, check_count = 0, cyc = 0;
    int order [4] = '{1, 2, 4, 3};
    ccrb_host host (.clk_i(clk), .valid_o(valid), .word_o(word));
    ccrb_bank dut (.REF_CLK_I(clk), .NRST_I(nrst), .WORD_VALID_I(valid), .WORD_I(word), .FIR_OVERFLOW_I(fir),
        .READ_WORD_O(rword), .READ_VALID_O(rvalid), .SOFT_RESET_O(sreset), .POWER_DOWN_O(pdn),
        .ADC_AUX_SEL_O(adc_aux), .MON_AUX_SEL_O(mon_aux), .MON_GAIN_O(mon_g), .DIG_LOOPBACK_O(dloop),
        .DAC16_MODE_O(dac16), .FLAG_O(flag), .PHONE_MODE_O(phone), .ADC16_MODE_O(adc16), .ANA_LOOPBACK_O(aloop),
        .DELAYED_FRAME_SYNC_EN_O(dfs_en), .FRAME_DELAY_O(dly), .FRAME_DELAY_BELOW_MIN_O(below),
        .SLAVE_COUNT_O(slv), .SLOTS_ACTIVE_O(slots), .PLL_BYPASS_O(byp), .RATE_DIVISOR_O(rate),
        .IN_GAIN_O(in_g), .OUT_GAIN_O(out_g));
    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk_out(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk_out
    task automatic chk_rd(input int a, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected read of register %0d: expected %h, seen %h", a, e, g);
        end
    endtask : chk_rd
    task automatic wr(input int a, input logic [7:0] d);
        host.send(1'b0, a[4:0], d, 2'h0);
        if (a >= 1 && a <= 4)
            r[a] = d;
    endtask : wr
    task automatic rd(input int a, input logic [15:0] m);
        logic [15:0] e;
        int k;
        e = (a >= 1 && a <= 4) ? {8'h00, r[a]} : 16'h0000;
        if (a == 2)
            e[5] = fir;
        host.send(1'b1, a[4:0], 8'h00, 2'h0);
        host.idle();
        k = 0;
        while (rvalid !== 1'b1 && k < 4)
        begin
            @(negedge clk);
            k++;
        end
        chk_out("read valid", 8'h01, {7'h0, rvalid});
        chk_rd(a, e & m, rword & m);
    endtask : rd
    task automatic outs();
        host.idle();
        repeat (2) @(negedge clk);
        chk_out("ctrl1", {1'b0, r[1][6:0]}, {1'b0, pdn, adc_aux, mon_aux, mon_g, dloop, dac16});
        chk_out("ctrl2", {3'h0, r[2][7:6], r[2][4:3], !r[2][2]}, {3'h0, flag, phone, adc16, aloop, dfs_en});
        chk_out("ctrl3", r[3], {slv, dly});
        chk_out("ctrl4", {r[4][7], 3'h0, r[4][3:0]}, {byp, 3'h0, in_g, out_g});
        chk_out("divisor", r[4][6:4] == 3'h0 ? 8'h08 : {5'h00, r[4][6:4]}, {4'h0, rate});
        chk_out("below min", {7'h0, r[3][5:0] < 6'h12}, {7'h0, below});
    endtask : outs
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            close_out();
        end
    end
    initial
    begin
        int i, k;
        logic [7:0] d;
        nrst = 1'b0;
        fir = 1'b0;
        r = '{default: 8'h00};
        k = $urandom(37);
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        outs();
        chk_out("slots", 8'h00, {7'h0, slots});
        for (i = 0; i < 8; i++)
            rd(i, 16'hFFFF);
        $display("test reset values done");
        fir = 1'b1;
        for (i = 0; i < 24; i++)
        begin
            k = order[i % 4];
            d = 8'($urandom);
            if (k == 1)
                d[7] = 1'b0;
            if (k == 2)
                d[1:0] = 2'h0;
            wr(k, d);
        end
        outs();
        chk_out("slots", 8'h01, {7'h0, slots});
        for (i = 1; i < 5; i++)
            rd(i, 16'hFFFF);
        fir = 1'b0;
        rd(2, 16'hFFFF);
        $display("test random writes done");
        for (i = 0; i < 8; i++)
        begin
            wr(1, {4'h0, i[1:0], 2'h0});
            wr(4, {i[0], i[2:0], i[1:0], ~i[1:0]});
            wr(3, i[0] ? 8'h11 : 8'h12);
            outs();
        end
        $display("test code tables done");
        host.send(1'b0, 5'h04, 8'hFF, 2'h2);
        host.send(1'b0, 5'h00, 8'hFF, 2'h0);
        host.send(1'b0, 5'h09, 8'hFF, 2'h0);
        host.send(1'b1, 5'h04, 8'h00, 2'h1);
        host.idle();
        for (i = 0; i < 2; i++)
        begin
            chk_out("refused read", 8'h00, {7'h0, rvalid});
            @(negedge clk);
        end
        outs();
        $display("test refused words done");
        wr(1, 8'hC1);
        host.idle();
        r[1] = 8'h41;
        k = 0;
        while (sreset !== 1'b1 && k < 4)
        begin
            @(negedge clk);
            k++;
        end
        for (i = 0; i < 3; i++)
        begin
            chk_out("soft reset", {7'h0, i < 2}, {7'h0, sreset});
            @(negedge clk);
        end
        rd(1, 16'h0080);
        for (i = 0; i < 4; i++)
            wr(order[i], r[order[i]]);
        outs();
        wr(1, 8'h80);
        host.idle();
        wr(1, 8'h06);
        outs();
        $display("test soft reset done");
        nrst = 1'b0;
        r = '{default: 8'h00};
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        outs();
        chk_out("slots", 8'h00, {7'h0, slots});
        rd(3, 16'hFFFF);
        $display("test mid-run reset done");
        close_out();
    end
endmodule : testbench
